//--- gpw_board.sv
// Board model: levels seen on the pins of the four ports.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Pin level model
module gpw_board
(
	input  wire logic        clk_sys,
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe,
	input  wire logic [31:0] pin_pu,
	input  wire logic [31:0] ext_val,
	input  wire logic [31:0] ext_en,
	output logic      [31:0] pin_in
);
	logic [31:0] float_q = 32'h00000000;

	// An undriven line without pull-up changes level every cycle.
	always_ff @(posedge clk_sys)
		float_q <= ~float_q;

	// Own drive first, then the switches, then the pull-up.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pu | float_q));
endmodule

`default_nettype wire

//--- gpw_params.svh
// Constants for the bidirectional port block: offsets, fields and resets.
`ifndef GPW_PARAMS_SVH
`define GPW_PARAMS_SVH

// ==========================================================================
// Register offsets
`define GPW_OFF_PORT_BASE	8'h00
`define GPW_PORT_STRIDE		8'h08
`define GPW_OFF_DIR		8'h04
`define GPW_OFF_OPTION		8'h20
`define GPW_OFF_SHARE		8'h24
`define GPW_OFF_POWER		8'h28
`define GPW_OFF_BITOP		8'h2c

// ==========================================================================
// Field positions
`define GPW_OPT_PULL_LO		0
`define GPW_OPT_PULL_HI		3
`define GPW_OPT_INT_BIT		4
`define GPW_OPT_WAKE_LO		8
`define GPW_OPT_WAKE_HI		15
`define GPW_SHR_CAP_LO		0
`define GPW_SHR_CAP_HI		7
`define GPW_SHR_RC_LO		8
`define GPW_SHR_RC_HI		11
`define GPW_PWR_DOWN_BIT	0
`define GPW_BOP_BIT_LO		0
`define GPW_BOP_BIT_HI		2
`define GPW_BOP_PORT_LO		4
`define GPW_BOP_PORT_HI		5
`define GPW_BOP_VAL_BIT		8
`define GPW_INT_PIN		5

// ==========================================================================
// Reset values and bus answers
`define GPW_PORT_RESET		8'hff
`define GPW_OPT_RESET		16'h0000
`define GPW_SHR_RESET		12'h000
`define GPW_RESP_OKAY		2'h0
`define GPW_RESP_DECERR		2'h3

`endif

//--- gpw_pkg.sv
// Types shared by the bidirectional port block.
`default_nettype none

package gpw_pkg;

	// ==================================================================
	// Power state of the core clock gate.
	typedef enum logic {
		GPW_PWR_RUN,
		GPW_PWR_DOWN
	} gpw_pwr_state_type;

	// One byte of port state.
	typedef logic [7:0] gpw_byte_type;

endpackage
`default_nettype wire

//--- gpw_port.sv
// One 8-bit port: output latch, direction bits, pin drive and read value.
`timescale 1ns/100ps
`default_nettype none
`include "gpw_params.svh"

module gpw_port
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       wr_data_en,
	input  wire logic       wr_dir_en,
	input  wire logic [7:0] wr_byte,
	input  wire logic [7:0] pin_sync,
	input  wire logic [7:0] share_mask,
	input  wire logic       pull_opt,
	output var  logic [7:0] latch_q,
	output var  logic [7:0] dir_q,
	output logic      [7:0] pad_oe,
	output logic      [7:0] pad_pullup,
	output logic      [7:0] rd_data
);

	// ==================================================================
	// Latch and direction hold until written; reset makes every pin input.
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			latch_q <= `GPW_PORT_RESET;
			dir_q   <= `GPW_PORT_RESET;
		end
		else
		begin
			if (wr_data_en)
				latch_q <= wr_byte;
			if (wr_dir_en)
				dir_q <= wr_byte;
		end
	end

	// Drive only output pins not taken by a shared function.
	assign pad_oe     = ~dir_q & ~share_mask;
	// Pull-up only on input pins when the option selects it.
	assign pad_pullup = {8{pull_opt}} & dir_q & ~share_mask;
	// Inputs read the live pin, outputs read the latch.
	assign rd_data    = (dir_q & pin_sync) | (~dir_q & latch_q);

	// ==================================================================
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_reset_all_high: assert property (
		$rose(nrst) |-> (latch_q == `GPW_PORT_RESET)
			&& (dir_q == `GPW_PORT_RESET))
		else $error("Port not all high after reset.");
	a_input_no_drive: assert property (
		(pad_oe & dir_q) == 8'h00)
		else $error("Input pin is driven.");
	a_latch_holds: assert property (
		!wr_data_en |=> $stable(latch_q))
		else $error("Latch changed without a write.");
	a_pull_on_input: assert property (
		(pad_pullup & ~dir_q) == 8'h00)
		else $error("Pull-up on an output pin.");

endmodule
`default_nettype wire

//--- gpw_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
`default_nettype none

module gpw_sync
#(
	parameter int WIDTH = 8
)
(
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_q;

	// ==================================================================
	// The first stage feeds only the second stage.
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			stage1_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1_q <= async_in;
			sync_out <= stage1_q;
		end
	end

endmodule
`default_nettype wire

//--- gpw_top.sv
// Four bidirectional ports with wake-up and pin sharing, on AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "gpw_params.svh"

// How it works
// - A direction bit of one makes its pin an input whose live level is read back.
// - A direction bit of zero drives the pin push-pull from its output latch.
// - Written output data stays in the latch until the latch is written again.
// - Reading an output pin returns the latch, not the level on the pin.
// - Inputs are not latched; the level is taken at the moment of the read.
// - Reset sets every data and direction bit of all four ports to one.
// - An input pin gets a weak pull-up when its port option selects it.
// - The power-down command stops the core clock until a wake-up comes.
// - While down, a high-to-low change on an enabled port A pin wakes it.
// - Wake-up is enabled per port A pin by its own option bit.
// - A single-bit set or clear reads the whole port and writes all eight bits.
// - The external interrupt shares port A bit 5, if shared and set to input.
// - Touch switch lines share port C, eight or four by variant, each by option.
// - Four converter oscillator pins share port D bits 0 to 3 when selected.
module gpw_top
#(
	parameter int CAP_LINES = 8
)
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  port_a_pins_in,
	output logic      [7:0]  port_a_pins_out,
	output logic      [7:0]  port_a_pins_oe,
	output logic      [7:0]  port_a_pullup,
	input  wire logic [7:0]  port_b_pins_in,
	output logic      [7:0]  port_b_pins_out,
	output logic      [7:0]  port_b_pins_oe,
	output logic      [7:0]  port_b_pullup,
	input  wire logic [7:0]  port_c_pins_in,
	output logic      [7:0]  port_c_pins_out,
	output logic      [7:0]  port_c_pins_oe,
	output logic      [7:0]  port_c_pullup,
	input  wire logic [7:0]  port_d_pins_in,
	output logic      [7:0]  port_d_pins_out,
	output logic      [7:0]  port_d_pins_oe,
	output logic      [7:0]  port_d_pullup,
	output logic             ext_int_n,
	output logic      [7:0]  touch_switch_lines_en,
	output logic      [3:0]  cap_switch_converter_osc_en,
	output logic             core_clock_en,
	output logic             powered_down
);

	// ==================================================================
	// Declarations.
	logic [3:0][7:0]                pin_raw;
	logic [3:0][7:0]                pin_sync;
	logic [3:0][7:0]                latch;
	logic [3:0][7:0]                dir;
	logic [3:0][7:0]                oe;
	logic [3:0][7:0]                pull;
	logic [3:0][7:0]                rd_port;
	logic [3:0][7:0]                share;
	logic [3:0][7:0]                port_wr_byte;
	logic [3:0]                     hit_wdata;
	logic [3:0]                     hit_wdir;
	logic [3:0]                     hit_rdata;
	logic [3:0]                     hit_rdir;
	logic [3:0]                     data_wr_en;
	logic [3:0]                     dir_wr_en;
	logic [15:0]                    opt_q;
	logic [11:0]                    shr_q;
	logic                           aw_got_q;
	logic                           w_got_q;
	logic [7:0]                     awaddr_q;
	logic [31:0]                    wdata_q;
	logic [3:0]                     wstrb_q;
	logic [7:0]                     wake_prev_q;
	gpw_pkg::gpw_pwr_state_type     pwr_q;
	gpw_pkg::gpw_pwr_state_type     pwr_d;
	logic                           wr_fire;
	logic                           rd_fire;
	logic                           hit_opt_w;
	logic                           hit_shr_w;
	logic                           hit_pwr_w;
	logic                           hit_bop_w;
	logic                           w_mapped;
	logic                           r_mapped;
	logic                           bop_fire;
	logic                           down_cmd;
	logic                           wake;
	logic [1:0]                     bop_port;
	logic [2:0]                     bop_bit;
	logic                           bop_val;
	logic [7:0]                     bop_byte;
	logic [7:0]                     wake_en;
	logic [3:0]                     pull_opt;
	logic [7:0]                     cap_sel;
	logic [3:0]                     rc_sel;
	logic [7:0]                     cap_mask;
	logic [31:0]                    rd_word;

	// ==================================================================
	// Pin grouping.
	assign pin_raw = {port_d_pins_in, port_c_pins_in,
		port_b_pins_in, port_a_pins_in};
	assign port_a_pins_out = latch[0];
	assign port_b_pins_out = latch[1];
	assign port_c_pins_out = latch[2];
	assign port_d_pins_out = latch[3];
	assign port_a_pins_oe  = oe[0];
	assign port_b_pins_oe  = oe[1];
	assign port_c_pins_oe  = oe[2];
	assign port_d_pins_oe  = oe[3];
	assign port_a_pullup   = pull[0];
	assign port_b_pullup   = pull[1];
	assign port_c_pullup   = pull[2];
	assign port_d_pullup   = pull[3];

	// Option fields.
	assign pull_opt = opt_q[`GPW_OPT_PULL_HI:`GPW_OPT_PULL_LO];
	assign wake_en  = opt_q[`GPW_OPT_WAKE_HI:`GPW_OPT_WAKE_LO];
	assign cap_mask = 8'(({8'h00, 8'hff} >> (8 - CAP_LINES)) & 16'h00ff);
	assign cap_sel  = shr_q[`GPW_SHR_CAP_HI:`GPW_SHR_CAP_LO] & cap_mask;
	assign rc_sel   = shr_q[`GPW_SHR_RC_HI:`GPW_SHR_RC_LO];
	assign share[0] = 8'h00;
	assign share[1] = 8'h00;
	assign share[2] = cap_sel;
	assign share[3] = {4'h0, rc_sel};
	assign touch_switch_lines_en       = cap_sel;
	assign cap_switch_converter_osc_en = rc_sel;

	// External interrupt follows port A bit 5 only when shared and input.
	assign ext_int_n = !(opt_q[`GPW_OPT_INT_BIT] && dir[0][`GPW_INT_PIN])
		|| pin_sync[0][`GPW_INT_PIN];

	// ==================================================================
	// Per-port synchroniser, decode and pin logic.
	for (genvar p = 0; p < 4; p++)
	begin : g_port
		localparam logic [7:0] OFF_D =
			8'(`GPW_OFF_PORT_BASE + p * `GPW_PORT_STRIDE);
		localparam logic [7:0] OFF_R = 8'(OFF_D + `GPW_OFF_DIR);

		assign hit_wdata[p]  = awaddr_q == OFF_D;
		assign hit_wdir[p]   = awaddr_q == OFF_R;
		assign hit_rdata[p]  = s_axi_araddr == OFF_D;
		assign hit_rdir[p]   = s_axi_araddr == OFF_R;
		assign data_wr_en[p] = (wr_fire && hit_wdata[p] && wstrb_q[0])
			|| (bop_fire && bop_port == 2'(p));
		assign dir_wr_en[p]  = wr_fire && hit_wdir[p] && wstrb_q[0];
		assign port_wr_byte[p] = bop_fire ? bop_byte : wdata_q[7:0];

		gpw_sync #(.WIDTH(8)) u_sync
		(
			.clk_sys  (clk_sys),
			.nrst     (nrst),
			.async_in (pin_raw[p]),
			.sync_out (pin_sync[p])
		);

		gpw_port u_port
		(
			.clk_sys    (clk_sys),
			.nrst       (nrst),
			.wr_data_en (data_wr_en[p]),
			.wr_dir_en  (dir_wr_en[p]),
			.wr_byte    (port_wr_byte[p]),
			.pin_sync   (pin_sync[p]),
			.share_mask (share[p]),
			.pull_opt   (pull_opt[p]),
			.latch_q    (latch[p]),
			.dir_q      (dir[p]),
			.pad_oe     (oe[p]),
			.pad_pullup (pull[p]),
			.rd_data    (rd_port[p])
		);
	end

	// ==================================================================
	// Write channel: address and data are taken in either order.
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
	assign wr_fire   = aw_got_q && w_got_q && !s_axi_bvalid;
	assign hit_opt_w = awaddr_q == `GPW_OFF_OPTION;
	assign hit_shr_w = awaddr_q == `GPW_OFF_SHARE;
	assign hit_pwr_w = awaddr_q == `GPW_OFF_POWER;
	assign hit_bop_w = awaddr_q == `GPW_OFF_BITOP;
	assign w_mapped  = (|hit_wdata) || (|hit_wdir) || hit_opt_w
		|| hit_shr_w || hit_pwr_w || hit_bop_w;

	// Bit operation reads the whole port and rewrites all eight bits.
	assign bop_fire = wr_fire && hit_bop_w && (&wstrb_q[1:0]);
	assign bop_port = wdata_q[`GPW_BOP_PORT_HI:`GPW_BOP_PORT_LO];
	assign bop_bit  = wdata_q[`GPW_BOP_BIT_HI:`GPW_BOP_BIT_LO];
	assign bop_val  = wdata_q[`GPW_BOP_VAL_BIT];
	assign bop_byte = bop_val ? (rd_port[bop_port] | (8'h01 << bop_bit))
		: (rd_port[bop_port] & ~(8'h01 << bop_bit));

	// Bus handshake state for writes.
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			aw_got_q     <= 1'b0;
			w_got_q      <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `GPW_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= w_mapped ? `GPW_RESP_OKAY
					: `GPW_RESP_DECERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Option and sharing registers, byte lane by byte lane.
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			opt_q <= `GPW_OPT_RESET;
			shr_q <= `GPW_SHR_RESET;
		end
		else if (wr_fire)
		begin
			if (hit_opt_w && wstrb_q[0])
				opt_q[7:0] <= wdata_q[7:0];
			if (hit_opt_w && wstrb_q[1])
				opt_q[15:8] <= wdata_q[15:8];
			if (hit_shr_w && wstrb_q[0])
				shr_q[7:0] <= wdata_q[7:0];
			if (hit_shr_w && wstrb_q[1])
				shr_q[11:8] <= wdata_q[11:8];
		end
	end

	// ==================================================================
	// Power-down and port A wake-up on a falling edge.
	assign down_cmd = wr_fire && hit_pwr_w && wstrb_q[0]
		&& wdata_q[`GPW_PWR_DOWN_BIT];
	assign wake     = |(wake_prev_q & ~pin_sync[0] & wake_en);
	assign pwr_d    = (pwr_q == gpw_pkg::GPW_PWR_RUN)
		? (down_cmd ? gpw_pkg::GPW_PWR_DOWN : gpw_pkg::GPW_PWR_RUN)
		: (wake ? gpw_pkg::GPW_PWR_RUN : gpw_pkg::GPW_PWR_DOWN);
	assign core_clock_en = pwr_q == gpw_pkg::GPW_PWR_RUN;
	assign powered_down  = pwr_q == gpw_pkg::GPW_PWR_DOWN;

	// Power state and previous port A level for edge detection.
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			pwr_q       <= gpw_pkg::GPW_PWR_RUN;
			wake_prev_q <= 8'h00;
		end
		else
		begin
			pwr_q       <= pwr_d;
			wake_prev_q <= pin_sync[0];
		end
	end

	// ==================================================================
	// Read channel: pins are sampled when the read is taken.
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire  = s_axi_arvalid && s_axi_arready;
	assign r_mapped = (|hit_rdata) || (|hit_rdir)
		|| s_axi_araddr == `GPW_OFF_OPTION
		|| s_axi_araddr == `GPW_OFF_SHARE
		|| s_axi_araddr == `GPW_OFF_POWER
		|| s_axi_araddr == `GPW_OFF_BITOP;

	// Read data selection.
	always_comb
	begin
		rd_word = 32'h0000_0000;
		for (int p = 0; p < 4; p++)
		begin
			if (hit_rdata[p])
				rd_word = {24'h000000, rd_port[p]};
			if (hit_rdir[p])
				rd_word = {24'h000000, dir[p]};
		end
		if (s_axi_araddr == `GPW_OFF_OPTION)
			rd_word = {16'h0000, opt_q};
		if (s_axi_araddr == `GPW_OFF_SHARE)
			rd_word = {20'h00000, shr_q};
		if (s_axi_araddr == `GPW_OFF_POWER)
			rd_word = {31'h0000_0000, powered_down};
	end

	// Read answer register.
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `GPW_RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= r_mapped ? `GPW_RESP_OKAY : `GPW_RESP_DECERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==================================================================
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_halt_stops_clock: assert property (
		(pwr_q == gpw_pkg::GPW_PWR_RUN) && down_cmd
		|=> !core_clock_en && powered_down)
		else $error("Power-down did not stop the clock.");
	a_wake_on_fall: assert property (
		powered_down && wake |=> core_clock_en)
		else $error("Falling edge did not wake the core.");
	a_stay_down: assert property (
		powered_down && !wake |=> powered_down)
		else $error("Woke without an enabled falling edge.");
	a_bitop_applied: assert property (
		bop_fire |=> latch[$past(bop_port)][$past(bop_bit)]
			== $past(bop_val))
		else $error("Bit operation not applied.");
	a_bitop_others: assert property (
		bop_fire |=> (latch[$past(bop_port)] & ~(8'h01 << $past(bop_bit)))
			== ($past(rd_port[bop_port]) & ~(8'h01 << $past(bop_bit))))
		else $error("Bit operation did not rewrite the read port.");
	a_int_gated: assert property (
		!(opt_q[`GPW_OPT_INT_BIT] && dir[0][`GPW_INT_PIN]) |-> ext_int_n)
		else $error("Interrupt seen while not shared as input.");
	a_output_drive: assert property (
		oe[1] == ~dir[1] && port_b_pins_out == latch[1])
		else $error("Output pin not driven from latch.");
	a_rc_no_drive: assert property (
		(port_d_pins_oe[3:0] & rc_sel) == 4'h0)
		else $error("Oscillator pin driven as I/O.");
	a_read_value: assert property (
		rd_fire && hit_rdata[1]
		|=> s_axi_rdata[7:0] == (($past(dir[1]) & $past(pin_sync[1]))
			| (~$past(dir[1]) & $past(latch[1]))))
		else $error("Port read returned the wrong value.");

endmodule
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the four-port block.
`timescale 1ns/100ps
`default_nettype none
`include "gpw_params.svh"

// ==========================================================================
// Bench top
module tb;
	localparam logic [1:0] OK = `GPW_RESP_OKAY;
	localparam logic [1:0] ERR = `GPW_RESP_DECERR;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, p_out, p_oe, p_pu, p_in;
	logic [31:0] ext_val = 32'h0;
	logic [31:0] ext_en = 32'h0;
	logic [7:0]  touch;
	logic [3:0]  osc;
	logic        int_n, clk_en, pdn;
	int          n_mismatch = 0;
	int          n_tests = 0;

	gpw_top gpw_top_inst (.clk_sys(clk_sys), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.port_a_pins_in(p_in[7:0]), .port_a_pins_out(p_out[7:0]),
		.port_a_pins_oe(p_oe[7:0]), .port_a_pullup(p_pu[7:0]),
		.port_b_pins_in(p_in[15:8]), .port_b_pins_out(p_out[15:8]),
		.port_b_pins_oe(p_oe[15:8]), .port_b_pullup(p_pu[15:8]),
		.port_c_pins_in(p_in[23:16]), .port_c_pins_out(p_out[23:16]),
		.port_c_pins_oe(p_oe[23:16]), .port_c_pullup(p_pu[23:16]),
		.port_d_pins_in(p_in[31:24]), .port_d_pins_out(p_out[31:24]),
		.port_d_pins_oe(p_oe[31:24]), .port_d_pullup(p_pu[31:24]),
		.ext_int_n(int_n), .touch_switch_lines_en(touch),
		.cap_switch_converter_osc_en(osc), .core_clock_en(clk_en),
		.powered_down(pdn));

	gpw_board gpw_board_inst (.clk_sys(clk_sys), .pin_out(p_out),
		.pin_oe(p_oe), .pin_pu(p_pu), .ext_val(ext_val),
		.ext_en(ext_en), .pin_in(p_in));

	// Clock of 4 ns period.
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end

	// Port read value: live pin for inputs, latch for outputs.
	function automatic logic [31:0] erd(input logic [31:0] d,
		input logic [31:0] l, input logic [31:0] p);
		return (d & p) | (~d & l);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report;
		$display("Counts: %0d mismatches, %0d tests", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic tmo;
		n_mismatch++;
		$display("MISMATCH wait expected answer seen none");
		final_report;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	// AXI4-Lite write; handshakes are judged on values held at the edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ah, wh, bh;
		logic [1:0] r;
		int i;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++)
		begin
			@(negedge clk_sys);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid & bready;
			r = bresp;
			@(posedge clk_sys);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			if (bh)
			begin
				bready <= 1'b0;
				break;
			end
		end
		if (i == 100)
			tmo;
		chk("bresp", 32'(er), 32'(r));
	endtask

	// AXI4-Lite read with expected data and response.
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ah, rh;
		logic [31:0] d;
		logic [1:0] r;
		int i;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++)
		begin
			@(negedge clk_sys);
			ah = arvalid & arready;
			rh = rvalid & rready;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ah)
				arvalid <= 1'b0;
			if (rh)
			begin
				rready <= 1'b0;
				break;
			end
		end
		if (i == 100)
			tmo;
		chk("rresp", 32'(er), 32'(r));
		chk("rdata", ed, d);
	endtask

	// Main sequence.
	initial
	begin
		logic [31:0] dv, lv, pv;
		logic [11:0] s;
		logic [7:0]  t;
		int          p, b, i;
		void'($urandom(15));
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		ext_val <= $urandom();
		ext_en <= 32'hffffffff;
		dv = 32'hffffffff;
		lv = 32'hffffffff;
		settle(4);
		chk("pins_out", lv, p_out);
		chk("pins_oe", 32'h0, p_oe);
		chk("pullup", 32'h0, p_pu);
		chk("int_n", 32'h1, 32'(int_n));
		chk("clock_en", 32'h1, 32'(clk_en));
		for (p = 0; p < 4; p++)
		begin
			rd(8'(8 * p), 32'(ext_val[8*p+:8]), OK);
			rd(8'(8 * p + 4), 32'hff, OK);
		end
		repeat (4)
		begin
			for (p = 0; p < 4; p++)
			begin
				lv[8*p+:8] = 8'($urandom());
				dv[8*p+:8] = 8'($urandom());
				wr(8'(8 * p), 32'(lv[8*p+:8]), OK);
				wr(8'(8 * p + 4), 32'(dv[8*p+:8]), OK);
			end
			@(posedge clk_sys);
			ext_en <= dv;
			ext_val <= $urandom();
			settle(4);
			chk("pins_out", lv, p_out);
			chk("pins_oe", ~dv, p_oe);
			pv = erd(dv, lv, ext_val);
			for (p = 0; p < 4; p++)
				rd(8'(8 * p), 32'(pv[8*p+:8]), OK);
		end
		t = 8'($urandom());
		wr(`GPW_OFF_OPTION, 32'(t[3:0]), OK);
		settle(1);
		chk("pullup", dv & {{8{t[3]}}, {8{t[2]}}, {8{t[1]}}, {8{t[0]}}},
			p_pu);
		wr(`GPW_OFF_OPTION, 32'hf, OK);
		@(posedge clk_sys);
		ext_en <= dv & $urandom();
		settle(4);
		pv = erd(dv, lv, ext_val | ~ext_en);
		for (p = 0; p < 4; p++)
			rd(8'(8 * p), 32'(pv[8*p+:8]), OK);
		s = 12'($urandom());
		wr(`GPW_OFF_SHARE, 32'(s), OK);
		settle(1);
		chk("touch", 32'(s[7:0]), 32'(touch));
		chk("osc", 32'(s[11:8]), 32'(osc));
		chk("pins_oe", ~dv & ~{4'h0, s, 16'h0}, p_oe);
		chk("pullup", dv & ~{4'h0, s, 16'h0}, p_pu);
		wr(`GPW_OFF_SHARE, 32'h0, OK);
		repeat (8)
		begin
			p = $urandom_range(3);
			b = $urandom_range(7);
			i = $urandom_range(1);
			pv = erd(dv, lv, ext_val | ~ext_en);
			t = pv[8*p+:8];
			t[b] = i[0];
			lv[8*p+:8] = t;
			wr(`GPW_OFF_BITOP, {23'h0, i[0], 2'h0, p[1:0], 1'h0, b[2:0]},
				OK);
			settle(1);
			chk("pins_out", lv, p_out);
		end
		rd(`GPW_OFF_BITOP, 32'h0, OK);
		@(posedge clk_sys);
		ext_en[5] <= 1'b1;
		ext_val[5] <= 1'b0;
		dv[5] = 1'b1;
		wr(`GPW_OFF_DIR, 32'(dv[7:0]), OK);
		wr(`GPW_OFF_OPTION, 32'h1f, OK);
		settle(4);
		chk("int_n", 32'h0, 32'(int_n));
		@(posedge clk_sys);
		ext_val[5] <= 1'b1;
		settle(4);
		chk("int_n", 32'h1, 32'(int_n));
		wr(`GPW_OFF_DIR, 32'hff, OK);
		@(posedge clk_sys);
		ext_en[7:0] <= 8'hff;
		ext_val[7:0] <= 8'hff;
		wr(`GPW_OFF_OPTION, 32'h040f, OK);
		wr(`GPW_OFF_POWER, 32'h1, OK);
		settle(1);
		chk("powered_down", 32'h1, 32'(pdn));
		chk("clock_en", 32'h0, 32'(clk_en));
		@(posedge clk_sys);
		ext_val[0] <= 1'b0;
		settle(6);
		chk("powered_down", 32'h1, 32'(pdn));
		rd(`GPW_OFF_POWER, 32'h1, OK);
		@(posedge clk_sys);
		ext_val[2] <= 1'b0;
		for (i = 0; i < 10 && pdn !== 1'b0; i++)
			@(negedge clk_sys);
		if (i == 10)
			tmo;
		chk("clock_en", 32'h1, 32'(clk_en));
		wr(8'h30, 32'h0, ERR);
		rd(8'h30, 32'h0, ERR);
		final_report;
	end
endmodule

`default_nettype wire
